//--- clock_cfg_pkg.sv
// shared constants, field layout and carrier types of the sampling pll configuration block
package clock_cfg_pkg;

  // ****************************************************************
  // serial control frame
  // ****************************************************************
  localparam int        FRAME_BITS  = 24;
  localparam logic [4:0] HEAD_LAST  = 5'h0f;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam int        ADDR_W      = 15;

  // ****************************************************************
  // register offsets and reset values
  // ****************************************************************
  localparam logic [14:0] OFS_FB_DIV_FIRST_SECOND = 15'h003d;
  localparam logic [14:0] OFS_FB_DIV_THIRD        = 15'h003e;
  localparam logic [14:0] OFS_OSC_BIAS            = 15'h003f;
  localparam logic [14:0] OFS_SER_EMPHASIS        = 15'h0048;
  localparam logic [14:0] OFS_AUX_OUTPUT          = 15'h0057;
  localparam logic [14:0] OFS_PIN_OVERRIDE        = 15'h0058;

  localparam logic [7:0] RST_FB_DIV_FIRST_SECOND = 8'h00;
  localparam logic [7:0] RST_FB_DIV_THIRD        = 8'h20;
  localparam logic [7:0] RST_OSC_BIAS            = 8'h4f;
  localparam logic [7:0] RST_SER_EMPHASIS        = 8'h00;
  localparam logic [7:0] RST_AUX_OUTPUT          = 8'h00;
  localparam logic [7:0] RST_PIN_OVERRIDE        = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int V_LSB    = 0;
  localparam int P_LSB    = 2;
  localparam int N_LSB    = 0;
  localparam int BIAS_LSB = 0;
  localparam int PE_LSB   = 0;
  localparam int AUX_MODE_LSB = 0;
  localparam int AUX_EN_BIT   = 7;
  localparam int OVR_EN_BIT   = 7;
  localparam int OVR_D_LSB    = 4;
  localparam int OVR_C_LSB    = 2;
  localparam int OVR_SE_BIT   = 1;
  localparam int OVR_PLL_BIT  = 0;

  localparam int LANES = 8;
  localparam int PE_W  = 4;

  // ****************************************************************
  // auxiliary output modes
  // ****************************************************************
  localparam logic [2:0] AUX_MODE_UI16 = 3'h0;
  localparam logic [2:0] AUX_MODE_UI32 = 3'h1;
  localparam logic [2:0] AUX_MODE_UI64 = 3'h2;
  localparam logic [2:0] AUX_MODE_TSTP = 3'h3;

  // toggle every ratio ticks, so a full period is twice the ratio
  localparam logic [5:0] AUX_HALF_UI16 = 6'h08;
  localparam logic [5:0] AUX_HALF_UI32 = 6'h10;
  localparam logic [5:0] AUX_HALF_UI64 = 6'h20;

  typedef struct packed {
    logic [1:0] d_mode;
    logic [1:0] c_mode;
    logic       ref_se;
    logic       pll_en;
  } pll_ctrl_s;

  // ****************************************************************
  // ratio decoders, zero means stopped
  // ****************************************************************
  function automatic logic [5:0] first_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    first_ratio = 6'h05;
      2'h1:    first_ratio = 6'h04;
      2'h2:    first_ratio = 6'h03;
      default: first_ratio = 6'h00;
    endcase
  endfunction : first_ratio

  // shared by the second feedback divider and both divided-reference outputs
  function automatic logic [5:0] binary_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    binary_ratio = 6'h01;
      2'h1:    binary_ratio = 6'h02;
      2'h2:    binary_ratio = 6'h04;
      default: binary_ratio = 6'h00;
    endcase
  endfunction : binary_ratio

endpackage : clock_cfg_pkg

//--- ratio_divider.sv
// programmable tick divider, one registered pulse every ratio input ticks
`timescale 1ns/1ps
module ratio_divider (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // control
  input  wire logic       run,
  input  wire logic [5:0] ratio,
  // ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [5:0] count;

  // ratio zero or run low clears the divider, so reserved codes give no clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count    <= 6'h00;
      tick_out <= 1'b0;
    end else if (!run || ratio == 6'h00) begin
      count    <= 6'h00;
      tick_out <= 1'b0;
    end else if (tick_in) begin
      if (count >= ratio - 6'h01) begin
        count    <= 6'h00;
        tick_out <= 1'b1;
      end else begin
        count    <= count + 6'h01;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule : ratio_divider

//--- sampling_pll_cfg.sv
// serial-port register set, feedback divider chain and auxiliary outputs of the sampling pll
`timescale 1ns/1ps

module sampling_pll_cfg (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  // serial control port
  input  wire logic        SCLK,
  input  wire logic        SCS_N,
  input  wire logic        SDI,
  output logic             SDO,
  output logic             SDO_OE_N,
  // configuration pins
  input  wire logic        PLL_EN_PIN,
  input  wire logic        PLLREF_SE_PIN,
  input  wire logic [1:0]  CLKCFG_PIN,
  input  wire logic        TIMESTAMP_INPUT,
  // timing events from neighbouring logic
  input  wire logic        OSC_TICK,
  input  wire logic        REF_TICK,
  input  wire logic        SER_UI_TICK,
  input  wire logic        SER_REINIT,
  // clock outputs
  output logic             SAMPLE_CLOCK,
  output logic             FEEDBACK_CLOCK,
  output logic             AUX_OUTPUT_PIN,
  output logic             FIRST_DIVIDED_REF,
  output logic             SECOND_DIVIDED_REF,
  // analog settings
  output logic             PLL_ENABLE,
  output logic             PLL_REF_SE,
  output logic [6:0]       OSCILLATOR_BIAS_LEVEL,
  output logic [31:0]      LANE_PREEMPHASIS
);

  typedef enum logic [1:0] {SP_IDLE, SP_HEAD, SP_DATA} spi_state_e;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int NPINS = 8;

  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_s1;
  logic [NPINS-1:0] pin_s2;
  logic [NPINS-1:0] pin_s3;
  logic [NPINS-1:0] pin_f;
  logic [NPINS-1:0] pin_f_d;

  assign pin_raw = {CLKCFG_PIN, PLLREF_SE_PIN, PLL_EN_PIN, TIMESTAMP_INPUT, SDI, SCS_N, SCLK};

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      // stages start at the idle levels, so chip select cannot look active after reset
      pin_s1 <= 8'h02;
      pin_s2 <= 8'h02;
      pin_s3 <= 8'h02;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // a level counts only once two later stages agree; chip select idles high
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_f   <= 8'h02;
      pin_f_d <= 8'h02;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_f[i] <= pin_s3[i];
        end
      end
      pin_f_d <= pin_f;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic sdi_f;
  logic tstamp_f;

  assign sclk_rise = pin_f[0] && !pin_f_d[0];
  assign sclk_fall = !pin_f[0] && pin_f_d[0];
  assign cs_active = !pin_f[1];
  assign sdi_f     = pin_f[2];
  assign tstamp_f  = pin_f[3];

  // ****************************************************************
  // serial frame engine
  // ****************************************************************
  spi_state_e  state;
  logic [4:0]  bit_count;
  logic [15:0] shift_in;
  logic        is_read;
  logic [14:0] frame_addr;
  logic [7:0]  out_shift;
  logic        wr_en;
  logic [14:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state      <= SP_IDLE;
      bit_count  <= 5'h00;
      shift_in   <= 16'h0000;
      is_read    <= 1'b0;
      frame_addr <= 15'h0000;
      wr_en      <= 1'b0;
      wr_addr    <= 15'h0000;
      wr_data    <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (!cs_active) begin
        state     <= SP_IDLE;
        bit_count <= 5'h00;
      end else begin
        case (state)
          SP_IDLE: begin
            state     <= SP_HEAD;
            bit_count <= 5'h00;
          end
          SP_HEAD: begin
            if (sclk_rise) begin
              shift_in  <= {shift_in[14:0], sdi_f};
              bit_count <= bit_count + 5'h01;
              if (bit_count == clock_cfg_pkg::HEAD_LAST) begin
                is_read    <= shift_in[14];
                frame_addr <= {shift_in[13:0], sdi_f};
                state      <= SP_DATA;
              end
            end
          end
          SP_DATA: begin
            if (sclk_rise) begin
              shift_in  <= {shift_in[14:0], sdi_f};
              bit_count <= bit_count + 5'h01;
              if (bit_count == clock_cfg_pkg::FRAME_LAST) begin
                wr_en   <= !is_read;
                wr_addr <= frame_addr;
                wr_data <= {shift_in[6:0], sdi_f};
                state   <= SP_IDLE;
              end
            end
          end
          default: state <= SP_IDLE;
        endcase
      end
    end
  end

  // read data launched on falling clock so it is stable at the next rise
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      out_shift <= 8'h00;
      SDO       <= 1'b0;
      SDO_OE_N  <= 1'b1;
    end else if (cs_active && state == SP_HEAD && sclk_rise &&
                 bit_count == clock_cfg_pkg::HEAD_LAST) begin
      // a write frame shifts zeros, so the undriven pin stays low
      out_shift <= shift_in[14] ? rd_data : 8'h00;
      SDO       <= shift_in[14] && rd_data[7];
      SDO_OE_N  <= !shift_in[14];
    end else if (state == SP_DATA && cs_active) begin
      if (sclk_fall) begin
        out_shift <= {out_shift[6:0], 1'b0};
        SDO       <= out_shift[6];
      end
    end else begin
      SDO_OE_N <= 1'b1;
      SDO      <= 1'b0;
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [7:0] fb_div_first_second;
  logic [7:0] fb_div_third;
  logic [7:0] osc_bias;
  logic [7:0] ser_emphasis;
  logic [7:0] aux_ctrl;
  logic [7:0] pin_override;

  // reserved bits are stored as written; software keeps them at reset value
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      fb_div_first_second <= clock_cfg_pkg::RST_FB_DIV_FIRST_SECOND;
      fb_div_third        <= clock_cfg_pkg::RST_FB_DIV_THIRD;
      osc_bias            <= clock_cfg_pkg::RST_OSC_BIAS;
      ser_emphasis        <= clock_cfg_pkg::RST_SER_EMPHASIS;
      aux_ctrl            <= clock_cfg_pkg::RST_AUX_OUTPUT;
      pin_override        <= clock_cfg_pkg::RST_PIN_OVERRIDE;
    end else if (wr_en) begin
      case (wr_addr)
        clock_cfg_pkg::OFS_FB_DIV_FIRST_SECOND: fb_div_first_second <= wr_data;
        clock_cfg_pkg::OFS_FB_DIV_THIRD:        fb_div_third        <= wr_data;
        clock_cfg_pkg::OFS_OSC_BIAS:            osc_bias            <= wr_data;
        clock_cfg_pkg::OFS_SER_EMPHASIS:        ser_emphasis        <= wr_data;
        clock_cfg_pkg::OFS_AUX_OUTPUT:          aux_ctrl            <= wr_data;
        clock_cfg_pkg::OFS_PIN_OVERRIDE:        pin_override        <= wr_data;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    case (frame_addr_next())
      clock_cfg_pkg::OFS_FB_DIV_FIRST_SECOND: rd_data = fb_div_first_second;
      clock_cfg_pkg::OFS_FB_DIV_THIRD:        rd_data = fb_div_third;
      clock_cfg_pkg::OFS_OSC_BIAS:            rd_data = osc_bias;
      clock_cfg_pkg::OFS_SER_EMPHASIS:        rd_data = ser_emphasis;
      clock_cfg_pkg::OFS_AUX_OUTPUT:          rd_data = aux_ctrl;
      clock_cfg_pkg::OFS_PIN_OVERRIDE:        rd_data = pin_override;
      default:                                rd_data = 8'h00;
    endcase
  end

  // the address is complete only with the bit arriving this cycle
  function automatic logic [14:0] frame_addr_next();
    frame_addr_next = {shift_in[13:0], sdi_f};
  endfunction : frame_addr_next

  // ****************************************************************
  // pin or register control of the pll
  // ****************************************************************
  clock_cfg_pkg::pll_ctrl_s ctrl;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctrl <= '0;
    end else if (pin_override[clock_cfg_pkg::OVR_EN_BIT]) begin
      ctrl.d_mode <= pin_override[clock_cfg_pkg::OVR_D_LSB +: 2];
      ctrl.c_mode <= pin_override[clock_cfg_pkg::OVR_C_LSB +: 2];
      ctrl.ref_se <= pin_override[clock_cfg_pkg::OVR_SE_BIT];
      ctrl.pll_en <= pin_override[clock_cfg_pkg::OVR_PLL_BIT];
    end else begin
      // pin mode: the config straps steer the first output, the second stays off
      ctrl.d_mode <= 2'h0;
      ctrl.c_mode <= pin_f[7:6];
      ctrl.ref_se <= pin_f[5];
      ctrl.pll_en <= pin_f[4];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PLL_ENABLE            <= 1'b0;
      PLL_REF_SE            <= 1'b0;
      OSCILLATOR_BIAS_LEVEL <= 7'h00;
      LANE_PREEMPHASIS      <= 32'h0000_0000;
    end else begin
      PLL_ENABLE            <= ctrl.pll_en;
      PLL_REF_SE            <= ctrl.ref_se;
      OSCILLATOR_BIAS_LEVEL <= osc_bias[clock_cfg_pkg::BIAS_LSB +: 7];
      LANE_PREEMPHASIS      <= {clock_cfg_pkg::LANES{
                                ser_emphasis[clock_cfg_pkg::PE_LSB +: 4]}};
    end
  end

  // ****************************************************************
  // feedback divider chain
  // ****************************************************************
  logic first_tick;
  logic sample_tick;
  logic feedback_tick;

  ratio_divider u_first (
    .clk      (CLOCK),
    .nrst     (NRST),
    .run      (ctrl.pll_en),
    .ratio    (clock_cfg_pkg::first_ratio(
                 fb_div_first_second[clock_cfg_pkg::V_LSB +: 2])),
    .tick_in  (OSC_TICK),
    .tick_out (first_tick)
  );

  ratio_divider u_second (
    .clk      (CLOCK),
    .nrst     (NRST),
    .run      (ctrl.pll_en),
    .ratio    (clock_cfg_pkg::binary_ratio(
                 fb_div_first_second[clock_cfg_pkg::P_LSB +: 2])),
    .tick_in  (first_tick),
    .tick_out (sample_tick)
  );

  ratio_divider u_third (
    .clk      (CLOCK),
    .nrst     (NRST),
    .run      (ctrl.pll_en),
    .ratio    (fb_div_third[clock_cfg_pkg::N_LSB +: 6]),
    .tick_in  (sample_tick),
    .tick_out (feedback_tick)
  );

  // ****************************************************************
  // auxiliary output and divided references
  // ****************************************************************
  logic [2:0] aux_mode;
  logic       aux_en;
  logic [5:0] aux_half;
  logic       aux_tick;
  logic       ref_c_tick;
  logic       ref_d_tick;

  assign aux_mode = aux_ctrl[clock_cfg_pkg::AUX_MODE_LSB +: 3];
  assign aux_en   = aux_ctrl[clock_cfg_pkg::AUX_EN_BIT];

  always_comb begin
    case (aux_mode)
      clock_cfg_pkg::AUX_MODE_UI16: aux_half = clock_cfg_pkg::AUX_HALF_UI16;
      clock_cfg_pkg::AUX_MODE_UI32: aux_half = clock_cfg_pkg::AUX_HALF_UI32;
      clock_cfg_pkg::AUX_MODE_UI64: aux_half = clock_cfg_pkg::AUX_HALF_UI64;
      default:                      aux_half = 6'h00;
    endcase
  end

  ratio_divider u_aux (
    .clk      (CLOCK),
    .nrst     (NRST),
    .run      (aux_en && !SER_REINIT),
    .ratio    (aux_half),
    .tick_in  (SER_UI_TICK),
    .tick_out (aux_tick)
  );

  ratio_divider u_ref_c (
    .clk      (CLOCK),
    .nrst     (NRST),
    .run      (ctrl.c_mode != 2'h0),
    .ratio    (clock_cfg_pkg::binary_ratio(ctrl.c_mode - 2'h1)),
    .tick_in  (REF_TICK),
    .tick_out (ref_c_tick)
  );

  // the second output only runs while the first one does
  ratio_divider u_ref_d (
    .clk      (CLOCK),
    .nrst     (NRST),
    .run      (ctrl.d_mode != 2'h0 && ctrl.c_mode != 2'h0),
    .ratio    (clock_cfg_pkg::binary_ratio(ctrl.d_mode - 2'h1)),
    .tick_in  (REF_TICK),
    .tick_out (ref_d_tick)
  );

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      SAMPLE_CLOCK   <= 1'b0;
      FEEDBACK_CLOCK <= 1'b0;
    end else if (!ctrl.pll_en) begin
      SAMPLE_CLOCK   <= 1'b0;
      FEEDBACK_CLOCK <= 1'b0;
    end else begin
      SAMPLE_CLOCK   <= SAMPLE_CLOCK ^ sample_tick;
      FEEDBACK_CLOCK <= FEEDBACK_CLOCK ^ feedback_tick;
    end
  end

  // clock modes follow the serializer, so a reinit parks the pin low
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      AUX_OUTPUT_PIN <= 1'b0;
    end else if (!aux_en) begin
      AUX_OUTPUT_PIN <= 1'b0;
    end else if (aux_mode == clock_cfg_pkg::AUX_MODE_TSTP) begin
      AUX_OUTPUT_PIN <= tstamp_f;
    end else if (aux_mode > clock_cfg_pkg::AUX_MODE_TSTP || SER_REINIT) begin
      AUX_OUTPUT_PIN <= 1'b0;
    end else begin
      AUX_OUTPUT_PIN <= AUX_OUTPUT_PIN ^ aux_tick;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      FIRST_DIVIDED_REF  <= 1'b0;
      SECOND_DIVIDED_REF <= 1'b0;
    end else begin
      FIRST_DIVIDED_REF  <= (ctrl.c_mode == 2'h0) ? 1'b0 : FIRST_DIVIDED_REF ^ ref_c_tick;
      SECOND_DIVIDED_REF <= (ctrl.d_mode == 2'h0 || ctrl.c_mode == 2'h0) ?
                            1'b0 : SECOND_DIVIDED_REF ^ ref_d_tick;
    end
  end

endmodule : sampling_pll_cfg

//--- sampling_pll_cfg_checker.sv
// concurrent checks on the ports of the sampling pll configuration block
`timescale 1ns/1ps
module sampling_pll_cfg_checker (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        NRST,
  // serial port
  input wire logic        SCS_N,
  input wire logic        SDO,
  input wire logic        SDO_OE_N,
  // timing events
  input wire logic        OSC_TICK,
  input wire logic        REF_TICK,
  input wire logic        SER_UI_TICK,
  input wire logic        TIMESTAMP_INPUT,
  // clock outputs and settings
  input wire logic        SAMPLE_CLOCK,
  input wire logic        FEEDBACK_CLOCK,
  input wire logic        AUX_OUTPUT_PIN,
  input wire logic        FIRST_DIVIDED_REF,
  input wire logic        SECOND_DIVIDED_REF,
  input wire logic        PLL_ENABLE,
  input wire logic [31:0] LANE_PREEMPHASIS
);
  // ****************************************************************
  // cycles since each cause, saturating so an edge long after its cause is caught
  // ****************************************************************
  logic            sample_q;
  logic            stamp_q;
  logic [2:0]      since [5];
  wire logic [4:0] ev = {TIMESTAMP_INPUT != stamp_q, SER_UI_TICK, REF_TICK,
                         SAMPLE_CLOCK != sample_q, OSC_TICK};

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sample_q <= 1'b0;
      stamp_q  <= 1'b0;
      for (int i = 0; i < 5; i++) since[i] <= 3'h7;
    end else begin
      sample_q <= SAMPLE_CLOCK;
      stamp_q  <= TIMESTAMP_INPUT;
      for (int i = 0; i < 5; i++) begin
        since[i] <= ev[i] ? 3'h0 : (since[i] == 3'h7 ? 3'h7 : since[i] + 3'h1);
      end
    end
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking dcb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_lane_copies: assert property (
    LANE_PREEMPHASIS == {8{LANE_PREEMPHASIS[3:0]}}) else $error("lanes differ");
  a_reset_quiet: assert property ($rose(NRST) |->
    !SAMPLE_CLOCK && !FEEDBACK_CLOCK && !AUX_OUTPUT_PIN && SDO_OE_N) else $error("not quiet");
  a_sample_gated: assert property (
    !PLL_ENABLE [*3] |-> !SAMPLE_CLOCK) else $error("sample clock without pll");
  a_sample_cause: assert property (
    $rose(SAMPLE_CLOCK) |-> since[0] <= 3'h5) else $error("sample edge without tick");
  a_feedback_cause: assert property (
    $rose(FEEDBACK_CLOCK) |-> since[1] <= 3'h5) else $error("feedback edge without sample");
  a_aux_cause: assert property (
    $rose(AUX_OUTPUT_PIN) |-> since[3] <= 3'h5 || since[4] <= 3'h5) else $error("aux edge");
  a_first_ref: assert property (
    $changed(FIRST_DIVIDED_REF) |-> since[2] <= 3'h5) else $error("first ref edge");
  a_second_ref: assert property (
    $rose(SECOND_DIVIDED_REF) |-> since[2] <= 3'h5) else $error("second ref edge");
  a_sdo_idle: assert property (SDO_OE_N |-> !SDO) else $error("sdo not idle");
  a_oe_release: assert property (SCS_N [*6] |-> SDO_OE_N) else $error("sdo still on");
endmodule : sampling_pll_cfg_checker

bind sampling_pll_cfg sampling_pll_cfg_checker u_sampling_pll_cfg_checker (
  .CLOCK, .NRST, .SCS_N, .SDO, .SDO_OE_N, .OSC_TICK, .REF_TICK, .SER_UI_TICK,
  .TIMESTAMP_INPUT, .SAMPLE_CLOCK, .FEEDBACK_CLOCK, .AUX_OUTPUT_PIN,
  .FIRST_DIVIDED_REF, .SECOND_DIVIDED_REF, .PLL_ENABLE, .LANE_PREEMPHASIS
);

//--- sampling_pll_and_aux_output_config_bench.sv
// self-checking bench for the sampling pll configuration block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module sampling_pll_and_aux_output_config_bench;
  logic        CLOCK, NRST, SCLK, SCS_N, SDI, SDO, SDO_OE_N;
  logic        PLL_EN_PIN, PLLREF_SE_PIN, TIMESTAMP_INPUT, SER_REINIT;
  logic        OSC_TICK, REF_TICK, SER_UI_TICK;
  logic [1:0]  CLKCFG_PIN;
  logic        SAMPLE_CLOCK, FEEDBACK_CLOCK, AUX_OUTPUT_PIN, PLL_ENABLE, PLL_REF_SE;
  logic        FIRST_DIVIDED_REF, SECOND_DIVIDED_REF;
  logic [6:0]  OSCILLATOR_BIAS_LEVEL;
  logic [31:0] LANE_PREEMPHASIS;
  int          fails, checked, seed, g, d;
  int          model [int];
  int          ofs [6] = '{8'h3d, 8'h3e, 8'h3f, 8'h48, 8'h57, 8'h58};
  int          rst [6] = '{8'h00, 8'h20, 8'h4f, 8'h00, 8'h00, 8'h00};
  // writable bits only, reserved bits stay at their reset value
  int          msk [6] = '{8'h0f, 8'h3f, 8'h7f, 8'h0f, 8'h87, 8'hbf};

  sampling_pll_cfg u_sampling_pll_cfg (
    .CLOCK, .NRST, .SCLK, .SCS_N, .SDI, .SDO, .SDO_OE_N, .PLL_EN_PIN, .PLLREF_SE_PIN,
    .CLKCFG_PIN, .TIMESTAMP_INPUT, .OSC_TICK, .REF_TICK, .SER_UI_TICK, .SER_REINIT,
    .SAMPLE_CLOCK, .FEEDBACK_CLOCK, .AUX_OUTPUT_PIN, .FIRST_DIVIDED_REF,
    .SECOND_DIVIDED_REF, .PLL_ENABLE, .PLL_REF_SE, .OSCILLATOR_BIAS_LEVEL, .LANE_PREEMPHASIS
  );

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  // ****************************************************************
  // serial frames and measurement
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #2;
  endtask : tick

  // every pin level stands four cycles, above the two the synchroniser needs
  task automatic frame(input logic r, input int a, input int wd, output logic [7:0] got);
    logic [23:0] bits;
    bits = {r, a[14:0], wd[7:0]};
    got = 8'h00;
    SCS_N = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      SDI = bits[i];
      tick(4);
      if (r && i < 8) begin
        got[i] = SDO;
        `CHK("read drive", 1'b0, SDO_OE_N)
      end
      SCLK = 1'b1;
      tick(4);
      SCLK = 1'b0;
    end
    tick(4);
    SCS_N = 1'b1;
    tick(8);
  endtask : frame

  task automatic wr(input int a, input int v);
    logic [7:0] x;
    frame(1'b0, a, v, x);
    if (model.exists(a)) model[a] = v & 8'hff;
  endtask : wr

  task automatic rd(input int a);
    logic [7:0] x;
    frame(1'b1, a, 8'h00, x);
    `CHK("register read", model.exists(a) ? model[a] : 0, x)
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: pick = SAMPLE_CLOCK;
      1: pick = FEEDBACK_CLOCK;
      2: pick = AUX_OUTPUT_PIN;
      3: pick = FIRST_DIVIDED_REF;
      default: pick = SECOND_DIVIDED_REF;
    endcase
  endfunction : pick

  // third interval only, so a partial first period never counts
  task automatic measure(input int s, output int n);
    logic v;
    for (int k = 0; k < 3; k++) begin
      v = pick(s);
      n = 0;
      while (pick(s) === v && n < 3000) begin
        tick(1);
        n++;
      end
    end
  endtask : measure

  task automatic quiet(input int s, input string nm);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      tick(1);
      seen |= pick(s);
    end
    `CHK(nm, 1'b0, seen)
  endtask : quiet

  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (80000) @(posedge CLOCK);
    fails++;
    conclude();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    seed = 6;
    {NRST, SCLK, SDI, PLL_EN_PIN, PLLREF_SE_PIN, TIMESTAMP_INPUT, SER_REINIT, CLKCFG_PIN} = '0;
    {SCS_N, OSC_TICK, REF_TICK, SER_UI_TICK} = '1;
    for (int i = 0; i < 6; i++) model[ofs[i]] = rst[i];
    tick(5);
    NRST = 1'b1;
    tick(6);
    for (int i = 0; i < 7; i++) rd(i < 6 ? ofs[i] : 8'h40);
    for (int i = 0; i < 7; i++) begin
      wr(i < 6 ? ofs[i] : 8'h40, $random(seed) & (i < 6 ? msk[i] : 8'hff));
      rd(i < 6 ? ofs[i] : 8'h40);
    end
    $display("test registers done");
    d = $random(seed) & 4'hf;
    wr(8'h48, d);
    wr(8'h3f, 8'h4a);
    `CHK("lane emphasis", {8{d[3:0]}}, LANE_PREEMPHASIS)
    `CHK("bias level", 7'h4a, OSCILLATOR_BIAS_LEVEL)
    PLLREF_SE_PIN = 1'b1;
    wr(8'h58, 8'h81);
    `CHK("pll enable", 1'b1, PLL_ENABLE)
    `CHK("ref select", 1'b0, PLL_REF_SE)
    wr(8'h58, 8'h00);
    `CHK("pll enable", 1'b0, PLL_ENABLE)
    `CHK("ref select", 1'b1, PLL_REF_SE)
    PLL_EN_PIN = 1'b1;
    tick(6);
    `CHK("pll enable", 1'b1, PLL_ENABLE)
    $display("test settings done");
    for (int v = 0; v < 3; v++)
      for (int p = 0; p < 3; p++) begin
        wr(8'h3d, p << 2 | v);
        measure(0, g);
        `CHK("sample half period", (5 - v) << p, g)
      end
    wr(8'h3d, 8'h02);
    foreach (ofs[i]) begin
      d = i == 0 ? 1 : (i == 5 ? 63 : 1 + ($random(seed) & 6'h3f) % 63);
      wr(8'h3e, d);
      measure(1, g);
      `CHK("feedback half period", 3 * d, g)
    end
    $display("test dividers done");
    for (int m = 0; m < 8; m++) begin
      wr(8'h57, model[8'h57] & 8'h07);
      wr(8'h57, m);
      wr(8'h57, 8'h80 | m);
      if (m < 3) begin
        measure(2, g);
        `CHK("aux half period", 8 << m, g)
        SER_REINIT = 1'b1;
        quiet(2, "aux reinit");
        SER_REINIT = 1'b0;
      end else if (m == 3) begin
        repeat (6) begin
          d = $random(seed);
          TIMESTAMP_INPUT = d[0];
          tick(8);
          `CHK("aux timestamp", TIMESTAMP_INPUT, AUX_OUTPUT_PIN)
        end
      end else quiet(2, "aux reserved");
    end
    wr(8'h57, 8'h07);
    wr(8'h57, 8'h01);
    quiet(2, "aux disabled");
    $display("test aux done");
    for (int c = 1; c < 4; c++) begin
      wr(8'h58, 8'h81 | c << 2 | c << 4);
      measure(3, g);
      `CHK("first ref", 1 << (c - 1), g)
      measure(4, g);
      `CHK("second ref", 1 << (c - 1), g)
    end
    wr(8'h58, 8'hb1);
    quiet(3, "first ref off");
    quiet(4, "second ref blocked");
    wr(8'h58, 8'h00);
    CLKCFG_PIN = 2'h2;
    measure(3, g);
    `CHK("pin ref", 2, g)
    $display("test refs done");
    conclude();
  end
endmodule : sampling_pll_and_aux_output_config_bench
